// ---- rtl/cpwm_pkg.sv ----
// Purpose: Shared constants and types for the compare PWM channel with fault shutdown
// Assumes: 32-bit Avalon-MM register bus, word addressed by byte offset
// Notes:   All offsets and fields, and the period and duty reset values, live here
package cpwm_pkg;

   // ************************************************************
   // Register map (byte offsets)
   // ************************************************************
   // All offsets share the address width, so no caller pads them
   localparam int         CPWM_ADDR_W      = 5;
   localparam logic [4:0] CPWM_OFS_CTRL    = 5'h00; // compare_control
   localparam logic [4:0] CPWM_OFS_PERIOD  = 5'h04; // Period in bus clocks minus one
   localparam logic [4:0] CPWM_OFS_DUTY    = 5'h08; // pwm_duty_compare
   localparam logic [4:0] CPWM_OFS_IRQSTAT = 5'h0C; // Sticky events, write one to clear
   localparam logic [4:0] CPWM_OFS_IRQMASK = 5'h10; // Interrupt mask

   // ************************************************************
   // compare_control fields
   // ************************************************************
   localparam int CPWM_CTRL_ON    = 0;  // Channel enable
   localparam int CPWM_CTRL_FLTEN = 1;  // Fault input mode enable
   localparam int CPWM_CTRL_OUT   = 2;  // Read-only: pin level
   localparam int CPWM_CTRL_FIN   = 3;  // Read-only: synchronised fault level
   localparam int CPWM_CTRL_FLAG  = 4;  // pwm_fault_flag

   // ************************************************************
   // Interrupt status and mask fields
   // ************************************************************
   localparam int CPWM_IRQ_W      = 2;
   localparam int CPWM_IRQ_FAULT  = 0;  // Fault detected
   localparam int CPWM_IRQ_PERIOD = 1;  // Period rollover

   // ************************************************************
   // Widths and reset values
   // ************************************************************
   localparam int          CPWM_CNT_W     = 16;
   localparam logic [15:0] CPWM_PERIOD_RST = 16'hFFFF;
   localparam logic [15:0] CPWM_DUTY_RST   = 16'h0000;
   localparam logic [15:0] CPWM_CNT_ONE    = 16'h0001;
   localparam int          CPWM_SYNC_STAGES = 2;

   // Avalon request bundle
   typedef struct packed {
      logic [CPWM_ADDR_W-1:0] address;
      logic                   read;
      logic                   write;
      logic [31:0]            writedata;
      logic [3:0]             byteenable;
   } cpwm_req_s;

   typedef enum logic [1:0] {
      CPWM_IDLE,
      CPWM_RUN,
      CPWM_SHUT
   } cpwm_state_e;

endpackage

// ---- rtl/cpwm_sync.sv ----
// Purpose: Two flip-flop level synchroniser
// Assumes: Input is asynchronous to clock
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module cpwm_sync (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Data
   input  wire logic din,
   output logic      dout
);
   import cpwm_pkg::*;

   logic meta_ff;

   // Two stages; reset to inactive
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_ff <= 1'b0;
         dout    <= 1'b0;
      end else begin
         meta_ff <= din;
         dout    <= meta_ff;
      end
   end

endmodule

// ---- rtl/cpwm_top.sv ----
// Purpose: Output compare channel in PWM mode with fault input shutdown
// Assumes: One 100 MHz bus clock, asynchronous fault pin, Avalon-MM slave
// Notes:   Pulse width is one clock longer than the duty value, capped at the full period
//
// How it works
// - The fault pin passes two flip-flops and the output register, so the output shuts down two to three clocks late.
// - The output stays high for the smaller of duty plus one and period plus one clocks in every period.
// - The fault flag cannot be cleared while the synchronised fault is still present and the channel and fault mode are on.
// - A fault raises its interrupt event once, on its first detection only.
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module cpwm_top (
   // Clock and reset
   input  wire logic                           clock,
   input  wire logic                           rst,
   // Avalon-MM slave
   input  wire logic [cpwm_pkg::CPWM_ADDR_W-1:0] avs_address,
   input  wire logic                           avs_read,
   input  wire logic                           avs_write,
   input  wire logic [31:0]                    avs_writedata,
   input  wire logic [3:0]                     avs_byteenable,
   output logic [31:0]                         avs_readdata,
   output logic                                avs_waitrequest,
   // Pins
   input  wire logic                           fault_in,
   output logic                                compare_channel,
   // Interrupt
   output logic                                irq
);
   import cpwm_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   cpwm_req_s             req;
   logic                  fault_sync;
   logic                  on_ff;
   logic                  flten_ff;
   logic                  flag_ff;
   logic [CPWM_CNT_W-1:0] period_ff;
   logic [CPWM_CNT_W-1:0] duty_ff;
   logic [CPWM_CNT_W-1:0] cnt_ff;
   logic [CPWM_IRQ_W-1:0] stat_ff;
   logic [CPWM_IRQ_W-1:0] mask_ff;
   logic                  ack_ff;
   cpwm_state_e           state_ff;
   logic                  wr_stb;
   logic                  rd_stb;
   logic                  wr_ctrl;
   logic                  fault_det;
   logic                  fault_new;
   logic                  roll;
   logic [CPWM_IRQ_W-1:0] ev;
   logic [CPWM_IRQ_W-1:0] w1c;
   logic [31:0]           nxt_rdata;

   assign req = '{address: avs_address, read: avs_read, write: avs_write,
                  writedata: avs_writedata, byteenable: avs_byteenable};

   // ************************************************************
   // Fault input synchroniser
   // ************************************************************
   // Synchronous detection adds one to two clocks of latency
   cpwm_sync u_fault_sync (
      .clock (clock),
      .rst   (rst),
      .din   (fault_in),
      .dout  (fault_sync)
   );

   // Fault counts only when fault mode is on and channel is enabled
   assign fault_det = fault_sync && flten_ff && on_ff;
   // Event only on the rising detection, so a persisting fault is one event
   assign fault_new = fault_det && !flag_ff;

   // ************************************************************
   // Bus slave
   // ************************************************************
   // One wait cycle per access: waitrequest drops the cycle after the request
   assign wr_stb  = req.write && ack_ff;
   assign rd_stb  = req.read && ack_ff;
   assign wr_ctrl = wr_stb && (req.address == CPWM_ADDR_W'(CPWM_OFS_CTRL)) && req.byteenable[0];

   // Waitrequest is high at idle and low for one cycle to complete an access
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ack_ff          <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else begin
         ack_ff          <= (req.read || req.write) && !ack_ff;
         avs_waitrequest <= !((req.read || req.write) && !ack_ff);
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (req.address == CPWM_ADDR_W'(CPWM_OFS_CTRL)) begin
         nxt_rdata[CPWM_CTRL_ON]    = on_ff;
         nxt_rdata[CPWM_CTRL_FLTEN] = flten_ff;
         nxt_rdata[CPWM_CTRL_OUT]   = compare_channel;
         nxt_rdata[CPWM_CTRL_FIN]   = fault_sync;
         nxt_rdata[CPWM_CTRL_FLAG]  = flag_ff;
      end else if (req.address == CPWM_ADDR_W'(CPWM_OFS_PERIOD)) begin
         nxt_rdata[CPWM_CNT_W-1:0] = period_ff;
      end else if (req.address == CPWM_ADDR_W'(CPWM_OFS_DUTY)) begin
         nxt_rdata[CPWM_CNT_W-1:0] = duty_ff;
      end else if (req.address == CPWM_ADDR_W'(CPWM_OFS_IRQSTAT)) begin
         nxt_rdata[CPWM_IRQ_W-1:0] = stat_ff;
      end else if (req.address == CPWM_OFS_IRQMASK) begin
         nxt_rdata[CPWM_IRQ_W-1:0] = mask_ff;
      end
   end

   // Read data registered so it is stable when waitrequest drops
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (req.read && !ack_ff) begin
         avs_readdata <= nxt_rdata;
      end
   end

   // ************************************************************
   // Configuration registers
   // ************************************************************
   // Byte lanes honoured for the wide registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         on_ff     <= 1'b0;
         flten_ff  <= 1'b0;
         period_ff <= CPWM_PERIOD_RST;
         duty_ff   <= CPWM_DUTY_RST;
         mask_ff   <= '0;
      end else if (wr_stb) begin
         if (req.address == CPWM_ADDR_W'(CPWM_OFS_CTRL)) begin
            if (req.byteenable[0]) begin
               on_ff    <= req.writedata[CPWM_CTRL_ON];
               flten_ff <= req.writedata[CPWM_CTRL_FLTEN];
            end
         end else if (req.address == CPWM_ADDR_W'(CPWM_OFS_PERIOD)) begin
            if (req.byteenable[0]) period_ff[7:0]  <= req.writedata[7:0];
            if (req.byteenable[1]) period_ff[15:8] <= req.writedata[15:8];
         end else if (req.address == CPWM_ADDR_W'(CPWM_OFS_DUTY)) begin
            // Software loads wanted width minus one
            if (req.byteenable[0]) duty_ff[7:0]  <= req.writedata[7:0];
            if (req.byteenable[1]) duty_ff[15:8] <= req.writedata[15:8];
         end else if (req.address == CPWM_OFS_IRQMASK) begin
            if (req.byteenable[0]) mask_ff <= req.writedata[CPWM_IRQ_W-1:0];
         end
      end
   end

   // ************************************************************
   // Fault flag
   // ************************************************************
   // Writing zero clears only while no fault is detected; detection wins
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flag_ff <= 1'b0;
      end else if (fault_det) begin
         flag_ff <= 1'b1;
      end else if (wr_ctrl && !req.writedata[CPWM_CTRL_FLAG]) begin
         flag_ff <= 1'b0;
      end
   end

   // ************************************************************
   // PWM state machine and counter
   // ************************************************************
   // Shutdown holds until flag cleared with no fault present, or until the channel is disabled
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_ff <= CPWM_IDLE;
      end else begin
         case (state_ff)
            CPWM_IDLE: begin
               if (on_ff) state_ff <= CPWM_RUN;
            end
            CPWM_RUN: begin
               if (!on_ff) state_ff <= CPWM_IDLE;
               else if (fault_det) state_ff <= CPWM_SHUT;
            end
            CPWM_SHUT: begin
               if (!on_ff) state_ff <= CPWM_IDLE;
               else if (!flag_ff && !fault_det) state_ff <= CPWM_RUN;
            end
            default: state_ff <= CPWM_IDLE;
         endcase
      end
   end

   assign roll = (state_ff == CPWM_RUN) && (cnt_ff == period_ff);

   // Free-running period counter, restarts on each run entry
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_ff <= '0;
      end else if (state_ff != CPWM_RUN || roll) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + CPWM_CNT_ONE;
      end
   end

   // High for counts 0..duty, i.e. duty plus one clocks
   // Fault forces low straight from the synchronised level
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         compare_channel <= 1'b0;
      end else if (fault_det || state_ff != CPWM_RUN) begin
         compare_channel <= 1'b0;
      end else begin
         compare_channel <= (cnt_ff <= duty_ff);
      end
   end

   // ************************************************************
   // Interrupt status, mask and output
   // ************************************************************
   assign ev = {roll, fault_new};
   assign w1c = (wr_stb && req.address == CPWM_ADDR_W'(CPWM_OFS_IRQSTAT) && req.byteenable[0])
                ? req.writedata[CPWM_IRQ_W-1:0] : '0;

   // Set wins over a simultaneous write-one clear
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stat_ff <= '0;
      end else begin
         stat_ff <= (stat_ff & ~w1c) | ev;
      end
   end

   // Level interrupt registered from masked status
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((stat_ff & ~w1c) | ev) & mask_ff);
      end
   end

endmodule

// ---- sim/compare_pwm_fault_shutdown_test.sv ----
// Purpose: Self-checking bench for the compare PWM channel
// Assumes: 100 MHz clock, Avalon-MM master tasks below
// Notes:   Pulse widths by table, faults and interrupts by hand
`timescale 1ns/1ps
module compare_pwm_fault_shutdown_test;
   import cpwm_pkg::*;
   logic                   clock, rst, avs_read, avs_write, avs_waitrequest;
   logic                   fault_req, fault_in, compare_channel, irq;
   logic [CPWM_ADDR_W-1:0] avs_address;
   logic [31:0]            avs_writedata, avs_readdata, rd;
   logic [15:0]            width_ff;
   int                     failures, n_compared;
   logic [4:0]             rst_addr [6] = '{5'h0, 5'h4, 5'h8, 5'hC, 5'h10, 5'h14};
   logic [31:0]            rst_exp  [6] = '{32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0};
   logic [15:0]            rows [3][2] = '{'{16'h0, 16'h1}, '{16'h3, 16'h4}, '{16'h8, 16'h9}};
   cpwm_top u_dut (.clock(clock), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .fault_in(fault_in),
      .compare_channel(compare_channel), .irq(irq));
   cpwm_load u_load (.clock(clock), .rst(rst), .compare_channel(compare_channel),
      .fault_req(fault_req), .fault_in(fault_in), .width_ff(width_ff));
   // ****************************************
   // Clock and tasks
   // ****************************************
   always #5 clock = ~clock;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // One access; an idle edge after release keeps strobes from toggling twice
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clock);
      if (n >= 50) begin
         failures++;
         tally_and_finish();
      end
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {clock, avs_read, avs_write, fault_req, avs_address, avs_writedata} = '0;
      failures = 0;
      n_compared = 0;
      rst = 1'b1;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      foreach (rst_addr[i]) begin
         bus(1'b0, rst_addr[i], 32'h0);
         chk(rd, rst_exp[i]);
      end
      $display("Reset values done");
      bus(1'b1, CPWM_OFS_PERIOD, 32'h9);
      bus(1'b1, CPWM_OFS_CTRL, 32'h1);
      foreach (rows[i]) begin
         bus(1'b1, CPWM_OFS_DUTY, {16'h0, rows[i][0]});
         repeat (40) @(posedge clock);
         chk({16'h0, width_ff}, {16'h0, rows[i][1]});
         $display("Pulse width %0d done", rows[i][1]);
      end
      // Fault with the interrupt unmasked, then a failed clear while it persists
      bus(1'b1, CPWM_OFS_IRQMASK, 32'h1);
      bus(1'b1, CPWM_OFS_CTRL, 32'h3);
      fault_req <= 1'b1;
      repeat (4) @(posedge clock);
      chk(32'(compare_channel), 32'h0);
      bus(1'b0, CPWM_OFS_CTRL, 32'h0);
      chk(32'(rd[CPWM_CTRL_FLAG]), 32'h1);
      chk(32'(irq), 32'h1);
      bus(1'b1, CPWM_OFS_CTRL, 32'h3);
      bus(1'b1, CPWM_OFS_IRQSTAT, 32'h1);
      bus(1'b0, CPWM_OFS_CTRL, 32'h0);
      chk(32'(rd[CPWM_CTRL_FLAG]), 32'h1);
      repeat (20) @(posedge clock);
      chk(32'(irq), 32'h0);
      bus(1'b0, CPWM_OFS_IRQSTAT, 32'h0);
      chk(32'(rd[CPWM_IRQ_FAULT]), 32'h0);
      chk(32'(rd[CPWM_IRQ_PERIOD]), 32'h1);
      // Fault gone: the clear now sticks
      fault_req <= 1'b0;
      repeat (5) @(posedge clock);
      bus(1'b1, CPWM_OFS_CTRL, 32'h3);
      bus(1'b0, CPWM_OFS_CTRL, 32'h0);
      chk(32'(rd[CPWM_CTRL_FLAG]), 32'h0);
      // Masked fault sets status only, unmasking raises irq, W1C drops it
      bus(1'b1, CPWM_OFS_IRQMASK, 32'h0);
      fault_req <= 1'b1;
      repeat (6) @(posedge clock);
      chk(32'(irq), 32'h0);
      bus(1'b0, CPWM_OFS_IRQSTAT, 32'h0);
      chk(32'(rd[CPWM_IRQ_FAULT]), 32'h1);
      bus(1'b1, CPWM_OFS_IRQMASK, 32'h1);
      @(posedge clock);
      chk(32'(irq), 32'h1);
      bus(1'b1, CPWM_OFS_IRQSTAT, 32'h1);
      @(posedge clock);
      chk(32'(irq), 32'h0);
      fault_req <= 1'b0;
      bus(1'b1, CPWM_OFS_CTRL, 32'h0);
      repeat (3) @(posedge clock);
      chk(32'(compare_channel), 32'h0);
      $display("Fault tests done");
      tally_and_finish();
   end
endmodule

// ---- sim/cpwm_checker.sv ----
// Purpose: Port checker for the compare PWM channel
// Assumes: Bound to cpwm_top; mode and mask learned from bus writes
// Notes:   Mirrors only the bits that the properties need
`timescale 1ns/1ps
module cpwm_checker (
   // Clock and reset
   input wire logic                             clock,
   input wire logic                             rst,
   // Bus
   input wire logic [cpwm_pkg::CPWM_ADDR_W-1:0] avs_address,
   input wire logic                             avs_read,
   input wire logic                             avs_write,
   input wire logic [31:0]                      avs_writedata,
   input wire logic                             avs_waitrequest,
   // Pins
   input wire logic                             fault_in,
   input wire logic                             compare_channel,
   input wire logic                             irq
);
   import cpwm_pkg::*;
   logic [1:0] mode_ff;
   logic       mask_ff;
   logic       wr_done;
   assign wr_done = avs_write && !avs_waitrequest;
   // Mirror on and fault-mode bits; the bus is the only view of the mode
   always_ff @(posedge clock or posedge rst) begin
      if (rst) mode_ff <= 2'h0;
      else if (wr_done && avs_address == 5'(CPWM_OFS_CTRL)) mode_ff <= avs_writedata[1:0];
   end
   // Mirror the fault mask bit
   always_ff @(posedge clock or posedge rst) begin
      if (rst) mask_ff <= 1'b0;
      else if (wr_done && avs_address == CPWM_OFS_IRQMASK) mask_ff <= avs_writedata[0];
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_fault_held;
      $rose(fault_in) && mode_ff == 2'h3 ##1 fault_in [*2];
   endsequence
   property p_shutdown;
      s_fault_held |=> !compare_channel;
   endproperty
   a_shutdown: assert property (p_shutdown)
      else $error("output still driven after fault");
   property p_hold;
      (mode_ff == 2'h3 && fault_in) [*4] |-> !compare_channel;
   endproperty
   a_hold: assert property (p_hold)
      else $error("output not held down during fault");
   property p_irq;
      s_fault_held ##1 mask_ff |-> ##[1:3] irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("fault did not raise irq");
   property p_irq_fall;
      // Status clear drops irq one edge after the write, a mask clear two edges after
      $fell(irq) |-> $past(wr_done) || $past(wr_done, 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("irq dropped without a write");
   property p_wait_pulse;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_pulse: assert property (p_wait_pulse)
      else $error("waitrequest low for more than one cycle");
   property p_answer;
      (avs_read || avs_write) && avs_waitrequest |-> ##[0:2] !avs_waitrequest;
   endproperty
   a_answer: assert property (p_answer)
      else $error("bus request not answered");
   property p_idle;
      !mode_ff[0] [*3] |-> !compare_channel;
   endproperty
   a_idle: assert property (p_idle)
      else $error("output high while channel off");
endmodule
bind cpwm_top cpwm_checker u_chk (.clock(clock), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_waitrequest(avs_waitrequest), .fault_in(fault_in),
   .compare_channel(compare_channel), .irq(irq));

// ---- sim/cpwm_load.sv ----
// Purpose: Power stage load and fault source beside the PWM pin
// Assumes: Fault pin is always driven by the source, never floating
// Notes:   Reports the width of the last completed high pulse
`timescale 1ns/1ps
module cpwm_load (
   // Clock and reset
   input wire logic   clock,
   input wire logic   rst,
   // Pins
   input wire logic   compare_channel,
   input wire logic   fault_req,
   output logic       fault_in,
   output logic [15:0] width_ff
);
   logic [15:0] run_ff;
   // Fault source follows the bench's request
   assign fault_in = fault_req;
   // Counts high clocks; extra high clocks before shutdown are tolerated
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         run_ff   <= 16'h0;
         width_ff <= 16'h0;
      end else if (compare_channel) begin
         run_ff <= run_ff + 16'h1;
      end else begin
         if (run_ff != 16'h0) width_ff <= run_ff;
         run_ff <= 16'h0;
      end
   end
endmodule
